// >>> rtl/frc_pkg.sv
package frc_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] IDX_RATE_WRITE   = 8'h04;
  localparam logic [7:0] IDX_DATA_PORT    = 8'h05;
  localparam logic [7:0] IDX_SENSE_CONFIG = 8'h07;
  localparam logic [7:0] IDX_MODE         = 8'h08;
  localparam logic [7:0] IDX_FIFO_SETUP   = 8'h09;
  localparam logic [7:0] IDX_STATUS       = 8'h0a;

  localparam logic [7:0] ADDR_RATE_WRITE   = {IDX_RATE_WRITE[5:0], 2'b00};
  localparam logic [7:0] ADDR_DATA_PORT    = {IDX_DATA_PORT[5:0], 2'b00};
  localparam logic [7:0] ADDR_SENSE_CONFIG = {IDX_SENSE_CONFIG[5:0], 2'b00};
  localparam logic [7:0] ADDR_MODE         = {IDX_MODE[5:0], 2'b00};
  localparam logic [7:0] ADDR_FIFO_SETUP   = {IDX_FIFO_SETUP[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS       = {IDX_STATUS[5:0], 2'b00};

  typedef enum logic [1:0]
  {
    MODE_BASIC = 2'h0,
    MODE_EXT1  = 2'h1,
    MODE_EXT2  = 2'h3
  } frc_mode_type;

  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;

  localparam logic [2:0] SHIFT_DEFAULT    = 3'h0;
  localparam logic [2:0] SHIFT_OFF        = 3'h7;
  localparam logic [2:0] SHIFT_NONE_STEPS = 3'h0;
  localparam logic [2:0] DEF_STEPS_LOW    = 3'h3;
  localparam logic [2:0] DEF_STEPS_1M     = 3'h1;

  // One shift step is 41.67 ns, held here in picoseconds.
  localparam logic [17:0] SHIFT_STEP_PS = 18'h0a2c6;

  // Field positions.
  localparam int RW_RESET_BIT    = 7;
  localparam int RW_PDOWN_BIT    = 6;
  localparam int RW_SHIFT_LSB    = 2;
  localparam int RATE_LSB        = 0;
  localparam int CC_SKIP_BIT     = 2;
  localparam int SENSE_MEDIA_BIT = 7;
  localparam int FS_EN_BIT       = 4;
  localparam int FS_THR_LSB      = 0;

  localparam logic [3:0] SENSE_EXT1_ONES = 4'hf;
  localparam logic [2:0] SENSE_EXT2_ONES = 3'h7;

  // Reset values.
  localparam logic [1:0] RATE_RESET  = RATE_500K;
  localparam logic [2:0] SHIFT_RESET = SHIFT_DEFAULT;
  localparam logic [3:0] THR_RESET   = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> rtl/frc_shift_if.sv
`timescale 1ns/10ps
interface frc_shift_if;
  logic [2:0]  write_shift_select;
  logic [1:0]  rate_select;
  logic [2:0]  shift_steps;
  logic [17:0] shift_delay_ps;

  modport regs
  (
    output write_shift_select,
    output rate_select,
    input  shift_steps,
    input  shift_delay_ps
  );

  modport calc
  (
    input  write_shift_select,
    input  rate_select,
    output shift_steps,
    output shift_delay_ps
  );
endinterface

// >>> rtl/frc_shift_calc.sv
`timescale 1ns/10ps
module frc_shift_calc
(
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  frc_shift_if.calc sh
);

  logic [2:0] steps_nxt;

  always_comb
  begin
    case (sh.write_shift_select)
      frc_pkg::SHIFT_DEFAULT:
      begin
        if (sh.rate_select == frc_pkg::RATE_1M)
        begin
          steps_nxt = frc_pkg::DEF_STEPS_1M;
        end
        else
        begin
          steps_nxt = frc_pkg::DEF_STEPS_LOW;
        end
      end
      frc_pkg::SHIFT_OFF: steps_nxt = frc_pkg::SHIFT_NONE_STEPS;
      default:            steps_nxt = sh.write_shift_select;
    endcase
  end

  // Registered so the shift never glitches while the rate is rewritten.
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      sh.shift_steps    <= frc_pkg::SHIFT_NONE_STEPS;
      sh.shift_delay_ps <= '0;
    end
    else
    begin
      sh.shift_steps    <= steps_nxt;
      sh.shift_delay_ps <= 18'(steps_nxt * frc_pkg::SHIFT_STEP_PS);
    end
  end

endmodule

// >>> rtl/frc_regs.sv
// How it works
// - Shift code maps to steps of 41.67 ns.
// - Default shift: 125 ns, 41.67 ns at 1M.
// - rate_select sets rate and write-current level.
// - Data port presents one of four stacked status bytes, picked by stack_sel_i.
// - FIFO disabled after reset; setup command changes it.
// - Basic mode: bit 7 inverted media change only.
// - First extended: media, ones, rate in bits 2:1.
// - First extended bit 0 flags low-density rates.
// - Second extended: raw media, ones, rate bits 1:0.
// - Second extended bit 3 mirrors transfer enable.
// - Second extended bit 2 returns skip flag.
// - Config write sets rate; reserved bits written zero.
// - Second extended config bit 2 stores skip flag.
// - Latest rate or config write decides the rate.
// - Rate write: shift bits 4:2, reset, power-down.
`timescale 1ns/10ps
module frc_regs
(
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        media_change_n_i,
  input  wire logic        transfer_req_en_i,
  input  wire logic [1:0]  stack_sel_i,
  input  wire logic [31:0] stack_bytes_i,
  output logic             data_wr_o,
  output logic [7:0]       data_byte_o,
  output logic             data_rd_o,
  output logic [1:0]       rate_select_o,
  output logic             low_write_current_n_o,
  output logic [2:0]       shift_steps_o,
  output logic [17:0]      shift_delay_ps_o,
  output logic             skip_shift_o,
  output logic             power_down_o,
  output logic             sw_reset_o,
  output logic             fifo_enable_o,
  output logic [3:0]       fifo_threshold_o
);

  typedef enum logic
  {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } frc_wr_state_type;

  typedef enum logic
  {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } frc_rd_state_type;

  frc_wr_state_type         wr_state_r;
  frc_rd_state_type         rd_state_r;
  logic                     aw_hold_r;
  logic                     w_hold_r;
  logic [7:0]               aw_addr_r;
  logic [31:0]              w_data_r;
  logic [3:0]               w_strb_r;
  logic [7:0]               wr_addr;
  logic [7:0]               wr_byte;
  logic                     wr_lane0;
  logic                     aw_have;
  logic                     w_have;
  logic                     do_write;
  logic                     do_read;
  logic                     rd_hit;
  logic [7:0]               rd_byte;
  logic                     wr_hit;
  logic [1:0]               rate_select_r;
  logic [2:0]               write_shift_select_r;
  logic                     skip_shift_r;
  logic                     power_down_r;
  logic                     fifo_enable_r;
  logic [3:0]               fifo_threshold_r;
  frc_pkg::frc_mode_type    mode_r;
  logic                     media_meta_r;
  logic                     media_sync_r;
  logic                     hd_media_flag;
  logic [7:0]               sense_byte;

  frc_shift_if sh_if ();

  frc_shift_calc u_shift
  (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .sh         (sh_if.calc)
  );

  assign sh_if.write_shift_select = write_shift_select_r;
  assign sh_if.rate_select        = rate_select_r;
  assign shift_steps_o            = sh_if.shift_steps;
  assign shift_delay_ps_o         = sh_if.shift_delay_ps;

  // Media change comes from the drive cable, so it is synchronised first.
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      media_meta_r <= 1'b1;
      media_sync_r <= 1'b1;
    end
    else
    begin
      media_meta_r <= media_change_n_i;
      media_sync_r <= media_meta_r;
    end
  end

  // Write channel: address and data are taken in either order.
  assign s_axi_awready_o = (wr_state_r == WR_IDLE) && !aw_hold_r;
  assign s_axi_wready_o  = (wr_state_r == WR_IDLE) && !w_hold_r;
  assign aw_have  = aw_hold_r || s_axi_awvalid_i;
  assign w_have   = w_hold_r || s_axi_wvalid_i;
  assign do_write = (wr_state_r == WR_IDLE) && aw_have && w_have;
  assign wr_addr  = aw_hold_r ? aw_addr_r : s_axi_awaddr_i;
  assign wr_byte  = w_hold_r ? w_data_r[7:0] : s_axi_wdata_i[7:0];
  assign wr_lane0 = w_hold_r ? w_strb_r[0] : s_axi_wstrb_i[0];

  always_comb
  begin
    case (wr_addr)
      frc_pkg::ADDR_RATE_WRITE:   wr_hit = 1'b1;
      frc_pkg::ADDR_DATA_PORT:    wr_hit = 1'b1;
      frc_pkg::ADDR_SENSE_CONFIG: wr_hit = 1'b1;
      frc_pkg::ADDR_MODE:         wr_hit = 1'b1;
      frc_pkg::ADDR_FIFO_SETUP:   wr_hit = 1'b1;
      default:                    wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      wr_state_r     <= WR_IDLE;
      aw_hold_r      <= 1'b0;
      w_hold_r       <= 1'b0;
      aw_addr_r      <= '0;
      w_data_r       <= '0;
      w_strb_r       <= '0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= frc_pkg::RESP_OKAY;
    end
    else
    begin
      case (wr_state_r)
        WR_IDLE:
        begin
          if (do_write)
          begin
            aw_hold_r      <= 1'b0;
            w_hold_r       <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? frc_pkg::RESP_OKAY
                                     : frc_pkg::RESP_SLVERR;
            wr_state_r     <= WR_RESP;
          end
          else
          begin
            if (s_axi_awvalid_i && !aw_hold_r)
            begin
              aw_hold_r <= 1'b1;
              aw_addr_r <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && !w_hold_r)
            begin
              w_hold_r <= 1'b1;
              w_data_r <= s_axi_wdata_i;
              w_strb_r <= s_axi_wstrb_i;
            end
          end
        end
        WR_RESP:
        begin
          if (s_axi_bready_i)
          begin
            s_axi_bvalid_o <= 1'b0;
            wr_state_r     <= WR_IDLE;
          end
        end
        default: wr_state_r <= WR_IDLE;
      endcase
    end
  end

  // Rate selection: whichever of the two registers was written last wins.
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      rate_select_r        <= frc_pkg::RATE_RESET;
      write_shift_select_r <= frc_pkg::SHIFT_RESET;
      power_down_r         <= 1'b0;
      skip_shift_r         <= 1'b0;
      mode_r               <= frc_pkg::MODE_BASIC;
    end
    else if (do_write && wr_lane0)
    begin
      case (wr_addr)
        frc_pkg::ADDR_RATE_WRITE:
        begin
          rate_select_r        <= wr_byte[frc_pkg::RATE_LSB +: 2];
          write_shift_select_r <= wr_byte[frc_pkg::RW_SHIFT_LSB +: 3];
          power_down_r         <= wr_byte[frc_pkg::RW_PDOWN_BIT];
        end
        frc_pkg::ADDR_SENSE_CONFIG:
        begin
          rate_select_r <= wr_byte[frc_pkg::RATE_LSB +: 2];
          if (mode_r == frc_pkg::MODE_EXT2)
          begin
            // The flag is stored for readback and drives skip_shift_o; the shift ignores it.
            skip_shift_r <= wr_byte[frc_pkg::CC_SKIP_BIT];
          end
        end
        frc_pkg::ADDR_MODE:
        begin
          case (wr_byte[1:0])
            frc_pkg::MODE_EXT1: mode_r <= frc_pkg::MODE_EXT1;
            frc_pkg::MODE_EXT2: mode_r <= frc_pkg::MODE_EXT2;
            default:            mode_r <= frc_pkg::MODE_BASIC;
          endcase
        end
        default: mode_r <= mode_r;
      endcase
    end
  end

  // Only the setup command may touch FIFO operation.
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      fifo_enable_r    <= 1'b0;
      fifo_threshold_r <= frc_pkg::THR_RESET;
    end
    else if (do_write && wr_lane0 && wr_addr == frc_pkg::ADDR_FIFO_SETUP)
    begin
      fifo_enable_r    <= wr_byte[frc_pkg::FS_EN_BIT];
      fifo_threshold_r <= wr_byte[frc_pkg::FS_THR_LSB +: 4];
    end
  end

  // Pulses toward the command engine and the soft reset.
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      data_wr_o   <= 1'b0;
      data_byte_o <= '0;
      sw_reset_o  <= 1'b0;
    end
    else
    begin
      data_wr_o  <= do_write && wr_lane0 &&
                    wr_addr == frc_pkg::ADDR_DATA_PORT;
      sw_reset_o <= do_write && wr_lane0 &&
                    wr_addr == frc_pkg::ADDR_RATE_WRITE &&
                    wr_byte[frc_pkg::RW_RESET_BIT];
      if (do_write && wr_lane0 && wr_addr == frc_pkg::ADDR_DATA_PORT)
      begin
        data_byte_o <= wr_byte;
      end
    end
  end

  // Input sense byte; bits that are undriven on a real bus read as zero.
  assign hd_media_flag = (rate_select_r == frc_pkg::RATE_250K) ||
                         (rate_select_r == frc_pkg::RATE_300K);

  always_comb
  begin
    case (mode_r)
      frc_pkg::MODE_EXT1:
      begin
        sense_byte = {!media_sync_r, frc_pkg::SENSE_EXT1_ONES,
                      rate_select_r, hd_media_flag};
      end
      frc_pkg::MODE_EXT2:
      begin
        sense_byte = {media_sync_r, frc_pkg::SENSE_EXT2_ONES,
                      transfer_req_en_i, skip_shift_r,
                      rate_select_r};
      end
      default:
      begin
        sense_byte = '0;
        sense_byte[frc_pkg::SENSE_MEDIA_BIT] = !media_sync_r;
      end
    endcase
  end

  // Read channel: one read at a time, answered the cycle after arvalid.
  assign s_axi_arready_o = (rd_state_r == RD_IDLE);
  assign do_read         = s_axi_arvalid_i && (rd_state_r == RD_IDLE);

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_byte = '0;
    case (s_axi_araddr_i)
      frc_pkg::ADDR_DATA_PORT:    rd_byte = stack_bytes_i[stack_sel_i*8 +: 8];
      frc_pkg::ADDR_SENSE_CONFIG: rd_byte = sense_byte;
      frc_pkg::ADDR_MODE:         rd_byte = {6'h00, mode_r};
      frc_pkg::ADDR_FIFO_SETUP:   rd_byte = {3'h0, fifo_enable_r,
                                             fifo_threshold_r};
      frc_pkg::ADDR_STATUS:       rd_byte = {power_down_r, skip_shift_r,
                                             sh_if.shift_steps,
                                             fifo_enable_r, rate_select_r};
      default:                    rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      rd_state_r     <= RD_IDLE;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= '0;
      s_axi_rresp_o  <= frc_pkg::RESP_OKAY;
      data_rd_o      <= 1'b0;
    end
    else
    begin
      data_rd_o <= do_read && s_axi_araddr_i == frc_pkg::ADDR_DATA_PORT;
      case (rd_state_r)
        RD_IDLE:
        begin
          if (do_read)
          begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= {24'h000000, rd_byte};
            s_axi_rresp_o  <= rd_hit ? frc_pkg::RESP_OKAY
                                     : frc_pkg::RESP_SLVERR;
            rd_state_r     <= RD_DATA;
          end
        end
        RD_DATA:
        begin
          if (s_axi_rready_i)
          begin
            s_axi_rvalid_o <= 1'b0;
            rd_state_r     <= RD_IDLE;
          end
        end
        default: rd_state_r <= RD_IDLE;
      endcase
    end
  end

  // Reduced write current is active low: high at 500k and 1M.
  assign low_write_current_n_o = (rate_select_r == frc_pkg::RATE_500K) ||
                                 (rate_select_r == frc_pkg::RATE_1M);
  assign rate_select_o    = rate_select_r;
  assign skip_shift_o     = skip_shift_r;
  assign power_down_o     = power_down_r;
  assign fifo_enable_o    = fifo_enable_r;
  assign fifo_threshold_o = fifo_threshold_r;

endmodule

// >>> dv/frc_drive_model.sv
`timescale 1ns/10ps
module frc_drive_model
#(
  parameter logic [31:0] STACK_BYTES = 32'h4b3a2918
)
(
  input  wire logic        eject_i,
  input  wire logic        dma_en_i,
  output logic             media_change_n_o,
  output logic             transfer_req_en_o,
  output logic [31:0]      stack_bytes_o
);
  // The drive reports a change as a low level that lasts while the door
  // flag is set, so the host can never miss it between two polls.
  assign media_change_n_o  = ~eject_i;
  assign transfer_req_en_o = dma_en_i;
  // Every stacked byte differs, so picking the wrong one shows at once.
  assign stack_bytes_o     = STACK_BYTES;
endmodule

// >>> dv/frc_regs_sva.sv
`timescale 1ns/10ps
module frc_regs_sva
(
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [1:0]  rate_select_o,
  input wire logic        low_write_current_n_o,
  input wire logic [2:0]  shift_steps_o,
  input wire logic [17:0] shift_delay_ps_o,
  input wire logic        sw_reset_o,
  input wire logic        fifo_enable_o,
  input wire logic        data_rd_o
);
  logic        wr_both;
  logic        rd_data;
  logic [31:0] wdata_q;
  assign wr_both = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
                   s_axi_wready_o && s_axi_wstrb_i[0];
  assign rd_data = s_axi_arvalid_i && s_axi_arready_o &&
                   (s_axi_araddr_i == frc_pkg::ADDR_DATA_PORT);
  always_ff @(posedge core_clk_i)
  begin
    wdata_q <= s_axi_wdata_i;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_lwc_level:
    assert property (low_write_current_n_o ==
                     (rate_select_o == 2'h0 || rate_select_o == 2'h3))
      else $error("write current level does not follow the rate");
  a_delay_steps:
    assert property (shift_steps_o != 3'h7 &&
                     shift_delay_ps_o == shift_steps_o * 18'h0a2c6)
      else $error("shift delay does not match its step count");
  a_resp_refuse:
    assert property (s_axi_bvalid_o |->
                     !s_axi_awready_o && !s_axi_wready_o)
      else $error("new write taken while a response is pending");
  a_rate_config:
    assert property (wr_both &&
                     s_axi_awaddr_i == frc_pkg::ADDR_SENSE_CONFIG |=>
                     rate_select_o == wdata_q[1:0])
      else $error("config write did not set the rate");
  a_rate_latest:
    assert property (wr_both &&
                     s_axi_awaddr_i == frc_pkg::ADDR_RATE_WRITE |=>
                     rate_select_o == wdata_q[1:0])
      else $error("rate write did not set the rate");
  a_soft_pulse:
    assert property (wr_both && s_axi_wdata_i[7] &&
                     s_axi_awaddr_i == frc_pkg::ADDR_RATE_WRITE |=>
                     sw_reset_o ##1 !sw_reset_o)
      else $error("soft reset is not a single pulse");
  a_fifo_setup:
    assert property ($changed(fifo_enable_o) |-> $past(wr_both) &&
                     $past(s_axi_awaddr_i) == frc_pkg::ADDR_FIFO_SETUP)
      else $error("fifo enable changed without a setup write");
  a_port_read:
    assert property (rd_data |=> data_rd_o)
      else $error("data port read not flagged");

  c_rate_write: cover property (wr_both &&
                  s_axi_awaddr_i == frc_pkg::ADDR_RATE_WRITE);
  c_port_read: cover property (rd_data);
  c_resp_error: cover property (s_axi_bvalid_o &&
                  s_axi_bresp_o == frc_pkg::RESP_SLVERR);
endmodule

bind frc_regs frc_regs_sva u_frc_regs_sva
(
  .core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
  .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .rate_select_o(rate_select_o),
  .low_write_current_n_o(low_write_current_n_o),
  .shift_steps_o(shift_steps_o), .shift_delay_ps_o(shift_delay_ps_o),
  .sw_reset_o(sw_reset_o), .fifo_enable_o(fifo_enable_o),
  .data_rd_o(data_rd_o)
);

// >>> dv/fdc_rate_and_input_regs_test.sv
`timescale 1ns/10ps
module fdc_rate_and_input_regs_test;
  localparam logic [31:0] STACK = 32'h4b3a2918;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        eject = 1'b0;
  logic        dma_en = 1'b0;
  logic [1:0]  stack_sel = 2'h0;
  logic [3:0]  wstrb = 4'h1;
  int          port_wr = 0;
  int          port_rd = 0;
  wire  logic  awready, wready, bvalid, arready, rvalid, media_n, treq;
  wire  logic  data_wr, data_rd, lwc_n, skip, pdown, swrst, fifo_en;
  wire  logic [1:0]  bresp, rresp, rate;
  wire  logic [2:0]  steps;
  wire  logic [3:0]  fifo_thr;
  wire  logic [7:0]  data_byte;
  wire  logic [17:0] delay;
  wire  logic [31:0] rdata, stack_bytes;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [1:0]  resp;
  logic [31:0] rd_val;
  logic [2:0]  exp_steps;

  frc_regs u_frc_regs
  (
    .core_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .media_change_n_i(media_n),
    .transfer_req_en_i(treq), .stack_sel_i(stack_sel),
    .stack_bytes_i(stack_bytes), .data_wr_o(data_wr),
    .data_byte_o(data_byte), .data_rd_o(data_rd), .rate_select_o(rate),
    .low_write_current_n_o(lwc_n), .shift_steps_o(steps),
    .shift_delay_ps_o(delay), .skip_shift_o(skip), .power_down_o(pdown),
    .sw_reset_o(swrst), .fifo_enable_o(fifo_en), .fifo_threshold_o(fifo_thr)
  );
  frc_drive_model #(.STACK_BYTES(STACK)) u_frc_drive_model
  (
    .eject_i(eject), .dma_en_i(dma_en), .media_change_n_o(media_n),
    .transfer_req_en_o(treq), .stack_bytes_o(stack_bytes)
  );

  always #5 clk = ~clk;

  // The data port strobes last one cycle, so they are counted here.
  always @(posedge clk)
  begin
    port_wr <= port_wr + data_wr;
    port_rd <= port_rd + data_rd;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Ready goes up with the request; one idle edge first keeps a lowered
  // ready from being raised again in the same time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        rd_val = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    check(rate, 32'h0);
    check(lwc_n, 32'h1);
    check(steps, 32'h3);
    check(fifo_en, 32'h0);
    rd(frc_pkg::ADDR_STATUS);
    check(rd_val, 32'h18);
    $display("reset test done");
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 8; c++)
      begin
        wr(frc_pkg::ADDR_RATE_WRITE, {3'h0, c[2:0], r[1:0]});
        exp_steps = (c == 0) ? ((r == 3) ? 3'h1 : 3'h3) : c[2:0];
        exp_steps = (c == 7) ? 3'h0 : exp_steps;
        repeat (2) @(posedge clk);
        check(rate, r[1:0]);
        check(lwc_n, (r == 0 || r == 3));
        check(steps, exp_steps);
        check(delay, exp_steps * 18'h0a2c6);
      end
    $display("shift table test done");
    wr(frc_pkg::ADDR_RATE_WRITE, 8'h01);
    wr(frc_pkg::ADDR_SENSE_CONFIG, 8'h02);
    check(rate, 32'h2);
    wr(frc_pkg::ADDR_RATE_WRITE, 8'h09);
    check(rate, 32'h1);
    $display("latest rate test done");
    eject <= 1'b1;
    dma_en <= 1'b1;
    repeat (4) @(posedge clk);
    wr(frc_pkg::ADDR_MODE, {6'h0, frc_pkg::MODE_BASIC});
    rd(frc_pkg::ADDR_SENSE_CONFIG);
    check(rd_val, 32'h80);
    wr(frc_pkg::ADDR_MODE, {6'h0, frc_pkg::MODE_EXT1});
    rd(frc_pkg::ADDR_SENSE_CONFIG);
    check(rd_val, 32'hfb);
    wr(frc_pkg::ADDR_SENSE_CONFIG, 8'h00);
    rd(frc_pkg::ADDR_SENSE_CONFIG);
    check(rd_val, 32'hf8);
    wr(frc_pkg::ADDR_MODE, {6'h0, frc_pkg::MODE_EXT2});
    wr(frc_pkg::ADDR_SENSE_CONFIG, 8'h06);
    check(skip, 32'h1);
    rd(frc_pkg::ADDR_SENSE_CONFIG);
    check(rd_val, 32'h7e);
    check(steps, 32'h2);
    eject <= 1'b0;
    dma_en <= 1'b0;
    repeat (4) @(posedge clk);
    wr(frc_pkg::ADDR_SENSE_CONFIG, 8'h01);
    rd(frc_pkg::ADDR_SENSE_CONFIG);
    check(rd_val, 32'hf1);
    wr(frc_pkg::ADDR_MODE, {6'h0, frc_pkg::MODE_BASIC});
    rd(frc_pkg::ADDR_SENSE_CONFIG);
    check(rd_val, 32'h00);
    $display("sense mode test done");
    wr(frc_pkg::ADDR_FIFO_SETUP, 8'h1a);
    check(fifo_en, 32'h1);
    check(fifo_thr, 32'ha);
    rd(frc_pkg::ADDR_FIFO_SETUP);
    check(rd_val, 32'h1a);
    for (int n = 0; n < 4; n++)
    begin
      stack_sel <= n[1:0];
      @(posedge clk);
      rd(frc_pkg::ADDR_DATA_PORT);
      check(rd_val, {24'h0, STACK[8*n +: 8]});
    end
    wr(frc_pkg::ADDR_DATA_PORT, 8'h5c);
    check(data_byte, 32'h5c);
    check(port_rd, 32'h4);
    $display("fifo and data port test done");
    wr(8'h30, 8'h03);
    check(resp, frc_pkg::RESP_SLVERR);
    check(rate, 32'h1);
    check(port_wr, 32'h1);
    rd(frc_pkg::ADDR_RATE_WRITE);
    check(resp, frc_pkg::RESP_SLVERR);
    wr(frc_pkg::ADDR_STATUS, 8'hff);
    check(resp, frc_pkg::RESP_SLVERR);
    wstrb <= 4'h0;
    wr(frc_pkg::ADDR_RATE_WRITE, 8'h02);
    check(resp, frc_pkg::RESP_OKAY);
    check(rate, 32'h1);
    wstrb <= 4'h1;
    wr(frc_pkg::ADDR_RATE_WRITE, 8'hc1);
    repeat (2) @(posedge clk);
    check(pdown, 32'h1);
    check(steps, 32'h3);
    wr(frc_pkg::ADDR_RATE_WRITE, 8'h01);
    check(pdown, 32'h0);
    $display("refusal and power test done");
    close_out();
  end
endmodule
